// ==== src/fsrs_flash_status.sv ====
// Overview of operation
// [R1] suspend halts ops; reads, erase-suspend programming
// [R2] held mode stalls CPU during program/erase
// [R3] held mode refuses commands to running block; code refuses only program and erase commands to it
// [R4] finish or suspend returns to read array
// [R5] enable plus software request enters suspend
// [R6] enable plus interrupt suspend on maskable irq
// [R7] held mode software suspend only data flash
// [R8] ready flag low whenever sequencer busy
// [R9] ready request ignores writes of one
// [R10] access-error request ignores writes of one
// [R11] ready request set on busy-to-ready
// [R12] access-error set on access to busy area
// [R13] command errors raise access-error when enabled
// [R14] access-error cleared by zero or clear command
// [R15] errors set on failure and command error
// [R16] lock monitor loaded at command completion; code loads it only when a program, erase or lock-bit read completes
// [R17] suspend status flags follow acknowledged suspend
// [R18] software keeps rewrite on while requests pending
// [R19] software runs from RAM, targets user ROM
// [R20] commands accepted only with rewrite enabled
// [R21] separate enable gates access-error on access
// [R22] interrupt output high while request set
`timescale 1ns/100ps
`default_nettype none

module fsrs_flash_status #(
    parameter logic [15:0] PROG_CYCLES  = fsrs_pkg::PROG_CYC,
    parameter logic [15:0] ERASE_CYCLES = fsrs_pkg::ERASE_CYC,
    parameter logic [15:0] MISC_CYCLES  = fsrs_pkg::MISC_CYC
) (
    // clock and reset
    input  wire logic               CLOCK,
    input  wire logic               RST_N,
    // wishbone slave
    input  wire logic               WB_CYC_I,
    input  wire logic               WB_STB_I,
    input  wire logic               WB_WE_I,
    input  wire logic [11:0]        WB_ADR_I,
    input  wire logic [3:0]         WB_SEL_I,
    input  wire logic [31:0]        WB_DAT_I,
    output logic      [31:0]        WB_DAT_O,
    output logic                    WB_ACK_O,
    // cpu flash accesses and events
    input  wire fsrs_pkg::fsrs_acc_t FLASH_ACC,
    input  wire logic               MASKABLE_IRQ,
    input  wire logic [2:0]         RUN_BLOCK,
    // flash array results
    input  wire logic               OP_FAIL,
    input  wire logic               LOCK_STATE,
    // outputs
    output logic                    CPU_HOLD,
    output logic                    READ_ARRAY,
    output logic                    ACCESS_REFUSED,
    output logic                    IRQ
);

    fsrs_pkg::fsrs_state_t state;
    fsrs_pkg::fsrs_state_t next_state;
    fsrs_pkg::fsrs_cmd_t   op;
    fsrs_pkg::fsrs_cmd_t   sub_op;
    fsrs_pkg::fsrs_cmd_t   cmd;
    logic [7:0] ctrl0;
    logic [7:0] susp;
    logic       prog_err;
    logic       erase_err;
    logic       lock_mon;
    logic       rdy_q;
    logic       acc_q;
    logic       main_done;
    logic       sub_done;
    logic       main_start;
    logic       sub_start;
    logic [15:0] main_len;
    logic       bus_req;
    logic       bus_wr;
    logic [9:0] idx;
    logic       cmd_go;
    logic       cmd_err;
    logic       clear_go;
    logic       do_suspend;
    logic       busy_to_ready;
    logic       finish_fail;
    logic       acc_hit;
    logic [7:0] status;
    logic       rewrite_en;
    logic       held;

    function automatic logic is_data(input logic [2:0] blk);
        is_data = blk >= fsrs_pkg::DATA_BLOCK_FIRST;
    endfunction

    function automatic logic is_rewrite(input logic [2:0] code);
        is_rewrite = code == fsrs_pkg::CMD_PROGRAM
                  || code == fsrs_pkg::CMD_ERASE;
    endfunction

    function automatic logic [15:0] op_len(input logic [2:0] code);
        case (code)
            fsrs_pkg::CMD_PROGRAM: op_len = PROG_CYCLES;
            fsrs_pkg::CMD_ERASE:   op_len = ERASE_CYCLES;
            default:               op_len = MISC_CYCLES;
        endcase
    endfunction

    assign rewrite_en = ctrl0[fsrs_pkg::C0_REWRITE];
    assign held       = ctrl0[fsrs_pkg::C0_HELD];
    assign bus_req    = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign bus_wr     = WB_CYC_I && WB_STB_I && WB_ACK_O
                     && WB_WE_I && WB_SEL_I[0];
    assign idx        = WB_ADR_I[11:2];
    assign cmd        = fsrs_pkg::fsrs_cmd_t'({
                            WB_DAT_I[fsrs_pkg::CMD_BLK_LSB +: 3],
                            WB_DAT_I[fsrs_pkg::CMD_CODE_LSB +: 3]});

    // [R20] rewrite enable gates commands
    assign cmd_go = bus_wr && idx == fsrs_pkg::IDX_CMD && rewrite_en;

    // command acceptance per state
    always_comb begin
        next_state = state;
        cmd_err    = 1'b0;
        clear_go   = 1'b0;
        main_start = 1'b0;
        sub_start  = 1'b0;
        do_suspend = 1'b0;
        case (state)
            fsrs_pkg::S_READY: begin
                if (cmd_go) begin
                    if (cmd.code == fsrs_pkg::CMD_CLEAR) begin
                        clear_go = 1'b1;
                    // [R3] refuse own block
                    end else if (held && is_rewrite(cmd.code)
                                 && cmd.block == RUN_BLOCK) begin
                        cmd_err = 1'b1;
                    end else if (cmd.code == fsrs_pkg::CMD_RESUME
                                 || cmd.code == 3'h0) begin
                        cmd_err = 1'b1;
                    end else begin
                        main_start = 1'b1;
                        next_state = fsrs_pkg::S_BUSY;
                    end
                end
            end
            fsrs_pkg::S_BUSY: begin
                cmd_err = cmd_go;
                // [R5] [R6] [R7] suspend entry
                if (is_rewrite(op.code) && susp[fsrs_pkg::SU_ENABLE]
                    && ((susp[fsrs_pkg::SU_SW_REQ]
                         && (!held || is_data(op.block)))
                        || (susp[fsrs_pkg::SU_IRQ_EN] && MASKABLE_IRQ))) begin
                    do_suspend = 1'b1;
                    next_state = fsrs_pkg::S_SUSP;
                end else if (main_done) begin
                    next_state = fsrs_pkg::S_READY;
                end
            end
            fsrs_pkg::S_SUSP: begin
                if (cmd_go) begin
                    if (cmd.code == fsrs_pkg::CMD_CLEAR) begin
                        clear_go = 1'b1;
                    end else if (cmd.code == fsrs_pkg::CMD_RESUME) begin
                        next_state = fsrs_pkg::S_BUSY;
                    // [R1] programming only in erase-suspend
                    end else if (cmd.code == fsrs_pkg::CMD_PROGRAM
                                 && op.code == fsrs_pkg::CMD_ERASE
                                 && cmd.block != op.block
                                 && !(held && cmd.block == RUN_BLOCK)) begin
                        sub_start  = 1'b1;
                        next_state = fsrs_pkg::S_SUSP_PROG;
                    end else begin
                        cmd_err = 1'b1;
                    end
                end
            end
            fsrs_pkg::S_SUSP_PROG: begin
                cmd_err = cmd_go;
                if (sub_done) begin
                    next_state = fsrs_pkg::S_SUSP;
                end
            end
            default: begin
                next_state = fsrs_pkg::S_READY;
            end
        endcase
    end

    assign main_len = op_len(cmd.code);

    // [R11] busy-to-ready events
    assign busy_to_ready = do_suspend
                        || (state == fsrs_pkg::S_BUSY && main_done)
                        || (state == fsrs_pkg::S_SUSP_PROG && sub_done);

    assign finish_fail = OP_FAIL
                      && ((state == fsrs_pkg::S_BUSY && main_done
                           && !do_suspend)
                          || (state == fsrs_pkg::S_SUSP_PROG && sub_done));

    // [R12] access to area being rewritten while busy
    always_comb begin
        acc_hit = 1'b0;
        if (FLASH_ACC.valid && state == fsrs_pkg::S_BUSY) begin
            acc_hit = FLASH_ACC.block == op.block
                   || (!FLASH_ACC.write && !is_data(op.block)
                       && is_data(FLASH_ACC.block));
        end else if (FLASH_ACC.valid
                     && state == fsrs_pkg::S_SUSP_PROG) begin
            acc_hit = FLASH_ACC.block == sub_op.block
                   || (!FLASH_ACC.write && !is_data(sub_op.block)
                       && is_data(FLASH_ACC.block));
        end
    end

    fsrs_op_timer #(
        .W      (fsrs_pkg::TIMER_W)
    ) u_main_timer (
        .CLOCK  (CLOCK),
        .RST_N  (RST_N),
        .start  (main_start),
        .length (main_len),
        .run    (state == fsrs_pkg::S_BUSY && !do_suspend),
        .done   (main_done)
    );

    fsrs_op_timer #(
        .W      (fsrs_pkg::TIMER_W)
    ) u_sub_timer (
        .CLOCK  (CLOCK),
        .RST_N  (RST_N),
        .start  (sub_start),
        .length (PROG_CYCLES),
        .run    (state == fsrs_pkg::S_SUSP_PROG),
        .done   (sub_done)
    );

    // [R9] [R11] ready request, writes of one ignored
    fsrs_req_flag u_rdy_flag (
        .CLOCK  (CLOCK),
        .RST_N  (RST_N),
        .set    (busy_to_ready && ctrl0[fsrs_pkg::C0_RDY_IE]),
        .clr    (bus_wr && idx == fsrs_pkg::IDX_STATUS
                 && !WB_DAT_I[fsrs_pkg::ST_RDY_IRQ]),
        .q      (rdy_q)
    );

    // [R10] [R13] [R14] [R21] access-error request
    fsrs_req_flag u_acc_flag (
        .CLOCK  (CLOCK),
        .RST_N  (RST_N),
        .set    ((acc_hit && ctrl0[fsrs_pkg::C0_ACC_IE])
                 || ((cmd_err || finish_fail)
                     && ctrl0[fsrs_pkg::C0_CMD_IE])),
        .clr    (clear_go
                 || (bus_wr && idx == fsrs_pkg::IDX_STATUS
                     && !WB_DAT_I[fsrs_pkg::ST_ACC_ERR])),
        .q      (acc_q)
    );

    // sequencer state and operands
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state  <= fsrs_pkg::S_READY;
            op     <= '0;
            sub_op <= '0;
        end else begin
            state <= next_state;
            if (main_start) begin
                op <= cmd;
            end
            if (sub_start) begin
                sub_op <= cmd;
            end
        end
    end

    // software registers
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ctrl0 <= fsrs_pkg::CTRL0_RESET;
            susp  <= fsrs_pkg::SUSP_RESET;
        end else begin
            if (bus_wr && idx == fsrs_pkg::IDX_CTRL0) begin
                ctrl0 <= WB_DAT_I[7:0] & 8'hE6;
            end
            if (bus_wr && idx == fsrs_pkg::IDX_SUSP) begin
                susp <= WB_DAT_I[7:0] & 8'h07;
            end
        end
    end

    // [R15] error flags
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            prog_err  <= 1'b0;
            erase_err <= 1'b0;
        end else if (cmd_err) begin
            prog_err  <= 1'b1;
            erase_err <= 1'b1;
        end else if (finish_fail) begin
            if (state == fsrs_pkg::S_SUSP_PROG
                || op.code == fsrs_pkg::CMD_PROGRAM) begin
                prog_err <= 1'b1;
            end else if (op.code == fsrs_pkg::CMD_ERASE
                         || op.code == fsrs_pkg::CMD_BLANK) begin
                erase_err <= 1'b1;
            end
        end else if (clear_go) begin
            prog_err  <= 1'b0;
            erase_err <= 1'b0;
        end
    end

    // [R16] lock monitor load on completion
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            lock_mon <= fsrs_pkg::LOCK_RESET;
        end else if (state == fsrs_pkg::S_BUSY && main_done
                     && !do_suspend
                     && (is_rewrite(op.code)
                         || op.code == fsrs_pkg::CMD_LOCK_READ)) begin
            lock_mon <= LOCK_STATE;
        end
    end

    // [R8] [R17] status byte
    always_comb begin
        status = 8'h00;
        status[fsrs_pkg::ST_READY] = state == fsrs_pkg::S_READY
                                  || state == fsrs_pkg::S_SUSP;
        status[fsrs_pkg::ST_ERASE_SUSP] = op.code == fsrs_pkg::CMD_ERASE
            && (state == fsrs_pkg::S_SUSP
                || state == fsrs_pkg::S_SUSP_PROG);
        status[fsrs_pkg::ST_ERASE_ERR] = erase_err;
        status[fsrs_pkg::ST_PROG_ERR]  = prog_err;
        status[fsrs_pkg::ST_PROG_SUSP] = state == fsrs_pkg::S_SUSP
            && op.code == fsrs_pkg::CMD_PROGRAM;
        status[fsrs_pkg::ST_LOCK]    = lock_mon;
        status[fsrs_pkg::ST_ACC_ERR] = acc_q;
        status[fsrs_pkg::ST_RDY_IRQ] = rdy_q;
    end

    // wishbone answer, one cycle after the request
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= bus_req;
            WB_DAT_O <= 32'h0000_0000;
            if (bus_req && !WB_WE_I) begin
                case (idx)
                    fsrs_pkg::IDX_STATUS: WB_DAT_O[7:0] <= status;
                    fsrs_pkg::IDX_CTRL0:  WB_DAT_O[7:0] <= ctrl0;
                    fsrs_pkg::IDX_SUSP:   WB_DAT_O[7:0] <= susp;
                    fsrs_pkg::IDX_CMD: begin
                        WB_DAT_O[fsrs_pkg::CMD_BLK_LSB +: 3] <= op.block;
                        WB_DAT_O[fsrs_pkg::CMD_CODE_LSB +: 3] <= op.code;
                    end
                    default: WB_DAT_O <= 32'h0000_0000;
                endcase
            end
        end
    end

    // [R2] [R4] [R22] registered outputs
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            CPU_HOLD       <= 1'b0;
            READ_ARRAY     <= 1'b1;
            ACCESS_REFUSED <= 1'b0;
            IRQ            <= 1'b0;
        end else begin
            CPU_HOLD <= held
                && ((next_state == fsrs_pkg::S_BUSY && is_rewrite(
                        main_start ? cmd.code : op.code))
                    || next_state == fsrs_pkg::S_SUSP_PROG);
            READ_ARRAY <= next_state == fsrs_pkg::S_READY
                       || next_state == fsrs_pkg::S_SUSP;
            ACCESS_REFUSED <= acc_hit;
            IRQ <= rdy_q || acc_q;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence seq_sw_suspend;
        state == fsrs_pkg::S_BUSY && op.code == fsrs_pkg::CMD_PROGRAM
        && susp[fsrs_pkg::SU_ENABLE] && susp[fsrs_pkg::SU_SW_REQ]
        && (!held || is_data(op.block));
    endsequence

    sequence seq_prog_suspended;
        state == fsrs_pkg::S_SUSP ##0 status[fsrs_pkg::ST_PROG_SUSP]
        ##0 READ_ARRAY;
    endsequence

    AST_HOLD_ONLY_BUSY: assert property ( // [R2]
        CPU_HOLD |-> state inside {fsrs_pkg::S_BUSY, fsrs_pkg::S_SUSP_PROG})
        else $error("cpu held while sequencer not busy");

    AST_REFUSE_OWN_BLOCK: assert property ( // [R3]
        state == fsrs_pkg::S_READY && cmd_go && held
        && cmd.code == fsrs_pkg::CMD_ERASE && cmd.block == RUN_BLOCK
        |=> state == fsrs_pkg::S_READY && erase_err && prog_err)
        else $error("erase of running block was not refused");

    AST_DONE_READ_ARRAY: assert property ( // [R4]
        state == fsrs_pkg::S_BUSY && main_done && !do_suspend
        |=> READ_ARRAY && status[fsrs_pkg::ST_READY])
        else $error("no read array after completion");

    AST_SW_SUSPEND: assert property ( // [R5]
        seq_sw_suspend |=> seq_prog_suspended)
        else $error("software suspend not entered");

    AST_READY_FLAG: assert property ( // [R8]
        main_start || sub_start |=> !status[fsrs_pkg::ST_READY])
        else $error("ready flag high after an operation started");

    AST_RDY_SET: assert property ( // [R11]
        busy_to_ready && ctrl0[fsrs_pkg::C0_RDY_IE] |=> rdy_q ##1 IRQ)
        else $error("ready request not raised");

    AST_ACC_NO_SW_SET: assert property ( // [R10]
        !acc_q && !acc_hit && !cmd_err && !finish_fail
        |=> !acc_q)
        else $error("access error set without cause");

    AST_CLEAR_CMD: assert property ( // [R14]
        clear_go && !acc_hit && !finish_fail |=> !acc_q && !prog_err)
        else $error("clear command did not clear");

    AST_NO_CMD_DISABLED: assert property ( // [R20]
        bus_wr && idx == fsrs_pkg::IDX_CMD && !rewrite_en
        && state == fsrs_pkg::S_READY |=> state == fsrs_pkg::S_READY)
        else $error("command accepted with rewrite disabled");

    AST_IRQ_FOLLOWS: assert property ( // [R22]
        (rdy_q || acc_q) [*2] |-> IRQ)
        else $error("interrupt output low with request set");

endmodule

`default_nettype wire

// ==== src/fsrs_op_timer.sv ====
`timescale 1ns/100ps
`default_nettype none

module fsrs_op_timer #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         CLOCK,
    input  wire logic         RST_N,
    // control
    input  wire logic         start,
    input  wire logic [W-1:0] length,
    input  wire logic         run,
    // status
    output logic              done
);

    logic [W-1:0] count;

    // counts down only while run, so a suspend freezes it
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            count <= '0;
        end else if (start) begin
            count <= length;
        end else if (run && count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign done = run && !start && (count == {{(W-1){1'b0}}, 1'b1});

endmodule

`default_nettype wire

// ==== src/fsrs_pkg.sv ====
package fsrs_pkg;

    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_STATUS = 10'h1B2;
    localparam logic [9:0] IDX_CTRL0  = 10'h1B4;
    localparam logic [9:0] IDX_SUSP   = 10'h1B6;
    localparam logic [9:0] IDX_CMD    = 10'h1B8;

    // flash_status fields
    localparam int ST_RDY_IRQ   = 0;
    localparam int ST_ACC_ERR   = 1;
    localparam int ST_LOCK      = 2;
    localparam int ST_PROG_SUSP = 3;
    localparam int ST_PROG_ERR  = 4;
    localparam int ST_ERASE_ERR = 5;
    localparam int ST_ERASE_SUSP = 6;
    localparam int ST_READY     = 7;

    // flash_control_0 fields
    localparam int C0_REWRITE = 1;
    localparam int C0_HELD    = 2;
    localparam int C0_CMD_IE  = 5;
    localparam int C0_ACC_IE  = 6;
    localparam int C0_RDY_IE  = 7;

    // flash_suspend_control fields
    localparam int SU_ENABLE  = 0;
    localparam int SU_SW_REQ  = 1;
    localparam int SU_IRQ_EN  = 2;

    // command register fields
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_BLK_LSB  = 4;

    // reset values
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] SUSP_RESET  = 8'h00;
    localparam logic       LOCK_RESET  = 1'h1;

    // command codes
    localparam logic [2:0] CMD_PROGRAM   = 3'h1;
    localparam logic [2:0] CMD_ERASE     = 3'h2;
    localparam logic [2:0] CMD_LOCK_PROG = 3'h3;
    localparam logic [2:0] CMD_LOCK_READ = 3'h4;
    localparam logic [2:0] CMD_BLANK     = 3'h5;
    localparam logic [2:0] CMD_CLEAR     = 3'h6;
    localparam logic [2:0] CMD_RESUME    = 3'h7;

    // first data flash block; lower numbers are program ROM
    localparam logic [2:0] DATA_BLOCK_FIRST = 3'h6;

    // busy durations in clock cycles
    localparam int         TIMER_W    = 16;
    localparam logic [15:0] PROG_CYC  = 16'h0040;
    localparam logic [15:0] ERASE_CYC = 16'h0200;
    localparam logic [15:0] MISC_CYC  = 16'h0010;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [2:0] block;
    } fsrs_acc_t;

    typedef struct packed {
        logic [2:0] block;
        logic [2:0] code;
    } fsrs_cmd_t;

    typedef enum logic [3:0] {
        S_READY     = 4'h1,
        S_BUSY      = 4'h2,
        S_SUSP      = 4'h4,
        S_SUSP_PROG = 4'h8
    } fsrs_state_t;

endpackage

// ==== src/fsrs_req_flag.sv ====
`timescale 1ns/100ps
`default_nettype none

module fsrs_req_flag (
    // clock and reset
    input  wire logic CLOCK,
    input  wire logic RST_N,
    // events
    input  wire logic set,
    input  wire logic clr,
    // flag
    output logic      q
);

    // set wins over a clear in the same cycle
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ==== tb/fsrs_cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module fsrs_cpu_model (
    // clock
    input  wire logic                CLOCK,
    // requests from the bench
    input  wire logic                go_acc,
    input  wire logic                go_irq,
    input  wire logic [2:0]          blk,
    // toward the block
    output var fsrs_pkg::fsrs_acc_t  acc,
    output logic                     mirq
);
    // reads aimed at user rom blocks
    always_ff @(posedge CLOCK) begin
        acc <= '{valid: go_acc, write: 1'b0, block: blk};
        mirq <= go_irq;
    end
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none

module testbench;
    localparam logic [9:0] ST = fsrs_pkg::IDX_STATUS;
    localparam logic [9:0] C0 = fsrs_pkg::IDX_CTRL0;
    localparam logic [9:0] SU = fsrs_pkg::IDX_SUSP;
    localparam logic [9:0] CM = fsrs_pkg::IDX_CMD;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        hold;
    logic        rarr;
    logic        irq;
    logic        go_acc = 1'b0;
    logic        go_irq = 1'b0;
    logic        fail = 1'b0;
    logic [2:0]  blk = 3'h0;
    logic        lock_st = 1'b0;
    logic        refused;
    logic [7:0]  n_refused = 8'h00;
    logic        mirq;
    logic [7:0]  s;
    fsrs_pkg::fsrs_acc_t acc;
    int          failures = 0;
    int          num_checks = 0;

    always #20 clk = ~clk;

    fsrs_cpu_model cpu (.CLOCK(clk), .go_acc(go_acc), .go_irq(go_irq),
        .blk(blk), .acc(acc), .mirq(mirq));

    fsrs_flash_status #(.PROG_CYCLES(16'h0010), .ERASE_CYCLES(16'h0010),
        .MISC_CYCLES(16'h0004)) dut (.CLOCK(clk), .RST_N(rst_n),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .FLASH_ACC(acc), .MASKABLE_IRQ(mirq), .RUN_BLOCK(3'h2),
        .OP_FAIL(fail), .LOCK_STATE(lock_st), .CPU_HOLD(hold),
        .READ_ARRAY(rarr), .ACCESS_REFUSED(refused), .IRQ(irq));

    always @(posedge clk)
        if (refused === 1'b1) n_refused <= n_refused + 8'h01;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [9:0] i,
                      input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) failures++;
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, i, d, q);
    endtask

    task automatic rd(input logic [9:0] i);
        wb(1'b0, i, 8'h00, s);
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            rd(ST);
            n++;
        end while (s[7] !== 1'b1 && n < 40);
    endtask

    task automatic pulse(input logic a, input logic q, input logic [2:0] b);
        @(posedge clk);
        go_acc <= a;
        go_irq <= q;
        blk <= b;
        @(posedge clk);
        go_acc <= 1'b0;
        go_irq <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset();
        rd(ST); check(s, 8'h84);
        rd(C0); check(s, 8'h00);
        rd(10'h000); check(s, 8'h00);
        wr(ST, 8'hFF);
        rd(ST); check(s, 8'h84);
        wr(CM, 8'h02);
        rd(ST); check(s, 8'h84);
    endtask

    task automatic t_erase();
        wr(C0, 8'hE2);
        wr(CM, 8'h02);
        rd(ST); check(s & 8'h80, 8'h00);
        pulse(1'b1, 1'b0, 3'h0);
        wait_ready();
        check(s, 8'h83);
        check({7'h0, irq}, 8'h01);
        check({7'h0, rarr}, 8'h01);
        check(n_refused, 8'h01);
        wr(ST, 8'h00);
        rd(ST); check(s, 8'h80);
        check({7'h0, irq}, 8'h00);
    endtask

    task automatic t_held();
        wr(C0, 8'hE6);
        wr(CM, 8'h22);
        rd(ST); check(s & 8'h20, 8'h20);
        wr(CM, 8'h06);
        wait_ready();
        wr(ST, 8'h00);
        wr(CM, 8'h12);
        @(posedge clk);
        check({7'h0, hold}, 8'h01);
        wait_ready();
        check({7'h0, hold}, 8'h00);
        wr(SU, 8'h03);
        wr(CM, 8'h01);
        rd(ST); check(s & 8'h88, 8'h00);
        wait_ready();
        wr(CM, 8'h61);
        rd(ST); check(s & 8'h88, 8'h88);
        wr(SU, 8'h00);
        lock_st <= 1'b1;
        wr(CM, 8'h07);
        wait_ready();
        check(s & 8'h88, 8'h80);
        check(s & 8'h04, 8'h04);
        lock_st <= 1'b0;
        wr(CM, 8'h04);
        wait_ready();
        check(s & 8'h84, 8'h80);
        wr(ST, 8'h00);
        wr(C0, 8'hE2);
    endtask

    task automatic t_susp();
        wr(SU, 8'h05);
        wr(CM, 8'h02);
        pulse(1'b0, 1'b1, 3'h0);
        rd(ST); check(s & 8'hC8, 8'hC0);
        check({7'h0, rarr}, 8'h01);
        wr(CM, 8'h11);
        rd(ST); check(s & 8'hC0, 8'h40);
        wr(SU, 8'h00);
        wait_ready();
        wr(CM, 8'h07);
        wait_ready();
        check(s & 8'hC8, 8'h80);
        wr(ST, 8'h00);
    endtask

    task automatic t_err();
        fail <= 1'b1;
        wr(CM, 8'h01);
        wait_ready();
        check(s & 8'h13, 8'h13);
        fail <= 1'b0;
        wr(CM, 8'h00);
        rd(ST); check(s & 8'h32, 8'h32);
        wr(CM, 8'h06);
        wait_ready();
        check(s & 8'h02, 8'h00);
        fail <= 1'b1;
        wr(CM, 8'h05);
        wait_ready();
        check(s & 8'h30, 8'h20);
        fail <= 1'b0;
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        give_verdict();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_erase();
        t_held();
        t_susp();
        t_err();
        give_verdict();
    end
endmodule

`default_nettype wire
